//--- bwd_core.sv
`timescale 1ns/10ps
module bwd_core (
  input  wire logic        clock,
  input  wire logic        rstN,
  input  wire logic        ce,
  input  wire logic [31:0] unitCycles,
  bwd_ctl_if.core          ctl,
  output logic             boardResetN_r
);

  bwd_pkg::bwd_state_t state_r;
  bwd_pkg::bwd_state_t state_nxt;
  logic [31:0]         count_r;
  logic [31:0]         hold_r;
  logic [31:0]         timeoutCycles;
  logic                expire;
  logic                fire;

  // ----------------------------------------------------------------
  // Timeout length
  // ----------------------------------------------------------------
  // Length is whole units, one to eight of them, from the select field
  assign timeoutCycles = unitCycles * ({29'h0, ctl.tmoSel} + 32'h1);
  assign expire        = (count_r == 32'h1) && !ctl.kick;
  // Watchdog reset: either expiry, or enabling while the flag still stands
  assign fire = ((state_r == bwd_pkg::BWD_RUN) && expire)
             || ((state_r == bwd_pkg::BWD_OFF) && ctl.runSet && ctl.resetFlag);
  assign ctl.running = (state_r == bwd_pkg::BWD_RUN);

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bwd_pkg::BWD_OFF: begin
        if (ctl.fullRst || fire) begin
          state_nxt = bwd_pkg::BWD_RESET;
        end else if (ctl.runSet) begin
          state_nxt = bwd_pkg::BWD_RUN;
        end
      end
      bwd_pkg::BWD_RUN: begin
        if (ctl.fullRst || fire) begin
          state_nxt = bwd_pkg::BWD_RESET;
        end else if (ctl.runClear && !ctl.lock) begin
          state_nxt = bwd_pkg::BWD_OFF;
        end
      end
      bwd_pkg::BWD_RESET: begin
        if (hold_r == 32'h1) begin
          state_nxt = bwd_pkg::BWD_OFF;
        end
      end
      default: begin
        state_nxt = bwd_pkg::BWD_OFF;
      end
    endcase
  end

  // State; off after power-on until software enables it
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state_r <= bwd_pkg::BWD_OFF;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Countdown, reloaded on start and on every kick
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      count_r <= 32'h0;
    end else if (ce) begin
      if (state_nxt != bwd_pkg::BWD_RUN) begin
        count_r <= 32'h0;
      end else if (state_r != bwd_pkg::BWD_RUN || ctl.kick) begin
        count_r <= timeoutCycles;
      end else begin
        count_r <= count_r - 32'h1;
      end
    end
  end

  // Reset pulse length; besides this reset, expiry sets the flag and stops the watchdog
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      hold_r        <= 32'h0;
      boardResetN_r <= 1'b1;
    end else if (ce) begin
      boardResetN_r <= (state_nxt != bwd_pkg::BWD_RESET);
      if (state_r != bwd_pkg::BWD_RESET) begin
        hold_r <= 32'(bwd_pkg::RST_HOLD_CYCLES);
      end else begin
        hold_r <= hold_r - 32'h1;
      end
    end
  end

  // Sticky flag; a new watchdog reset wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ctl.resetFlag <= 1'b0;
    end else if (ce) begin
      if (fire) begin
        ctl.resetFlag <= 1'b1;
      end else if (ctl.cfgWr || ctl.fullRst) begin
        ctl.resetFlag <= 1'b0;
      end
    end
  end

endmodule : bwd_core

//--- bwd_ctl_if.sv
`timescale 1ns/10ps
interface bwd_ctl_if;
  logic                                  cfgWr;
  logic                                  runSet;
  logic                                  runClear;
  logic                                  kick;
  logic                                  fullRst;
  logic                                  lock;
  logic [bwd_pkg::TMO_SEL_W-1:0]          tmoSel;
  logic                                  running;
  logic                                  resetFlag;

  modport regs (output cfgWr, runSet, runClear, kick, fullRst, lock, tmoSel,
                input running, resetFlag);
  modport core (input cfgWr, runSet, runClear, kick, fullRst, lock, tmoSel,
                output running, resetFlag);
endinterface : bwd_ctl_if

//--- bwd_pkg.sv
package bwd_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [15:0] BOARD_STATUS_IDX   = 16'h8200;
  localparam logic [15:0] BOARD_CONTROL_IDX  = 16'h8201;
  localparam logic [15:0] OPTION_ID_IDX      = 16'h8202;
  localparam logic [15:0] WDG_CONFIG_IDX     = 16'h8203;
  localparam logic [15:0] BOARD_SETUP_IDX    = 16'h8205;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          STATUS_FLAG_BIT    = 4;
  localparam int          KICK_BIT           = 6;
  localparam int          RUN_BIT            = 6;
  localparam int          READY_LED_BIT      = 7;
  localparam int          USB_ALL_BIT        = 1;
  localparam int          USB_LOW_BIT        = 0;
  localparam int          CFG_LOCK_BIT       = 7;
  localparam int          CFG_TMO_LSB        = 0;
  localparam int          TMO_SEL_W          = 3;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  CONTROL_RESET      = 8'h00;
  localparam logic [7:0]  CONFIG_RESET       = 8'h00;
  localparam logic [7:0]  SETUP_RESET        = 8'h01;
  localparam logic [7:0]  FULL_RESET_CODE    = 8'hA5;
  localparam logic [7:0]  OPTION_ID_VALUE    = 8'h3C;  // Arbitrary identification value

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_PS      = 8000;
  localparam int          TMO_UNIT_NS        = 1000000;
  localparam int          TMO_UNIT_CYCLES    = (TMO_UNIT_NS / CLK_PERIOD_PS) * 1000;
  localparam int          RST_HOLD_NS        = 1000;
  localparam int          RST_HOLD_CYCLES    = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;

  // Watchdog core states
  typedef enum logic [1:0] {
    BWD_OFF   = 2'b00,
    BWD_RUN   = 2'b01,
    BWD_RESET = 2'b10
  } bwd_state_t;

endpackage : bwd_pkg

//--- bwd_reset_sync.sv
`timescale 1ns/10ps
module bwd_reset_sync (
  input  wire logic clock,
  input  wire logic resetn,
  output logic      syncResetn
);

  logic stage_r;

  // ----------------------------------------------------------------
  // Release of reset through two flops, assertion stays asynchronous
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage_r    <= 1'b0;
      syncResetn <= 1'b0;
    end else begin
      stage_r    <= 1'b1;
      syncResetn <= stage_r;
    end
  end

endmodule : bwd_reset_sync

//--- bwd_watchdog.sv
`timescale 1ns/10ps
// Behaviour
// - After power-on the watchdog is off with no countdown until software enables it.
// - Timeout length and lock option come from the configuration register.
// - Setting bit 6 of the setup register starts the countdown.
// - With no kick before the timeout ends, a board reset is asserted.
// - Every change of control bit 6 is a kick and restarts the timeout.
// - A watchdog reset sets a sticky flag, status bit 4.
// - Writing A5 to the option register causes a complete reset, clearing the flag.
// - Any write to the configuration register clears the flag.
// - Enabling while the flag stands causes another reset at once.
// - With lock set, clearing the run bit is ignored.
// - Without lock, clearing setup bit 6 stops the countdown.
// - Expiry resets the board, sets the flag and stops the watchdog; no other action exists.
// - The run bit reads 1 while running and 0 while off.
// - The complete reset through the option register also clears the flag.
module bwd_watchdog #(
  parameter int unsigned UNIT_CYCLES = bwd_pkg::TMO_UNIT_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             boardResetN,
  output logic             watchdogActive,
  output logic             greenLed,
  output logic             usbPowerEn
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bwd_ctl_if   ctl ();

  logic        rstN;
  logic [7:0]  control_r;
  logic [7:0]  config_r;
  logic        ready_r;
  logic        usbAll_r;
  logic        usbLow_r;
  logic        cfgWr_r;
  logic        runSet_r;
  logic        runClear_r;
  logic        kick_r;
  logic        fullRst_r;
  logic        resetOut;
  logic [15:0] regIdx;
  logic        aligned;
  logic        hitStatus;
  logic        hitControl;
  logic        hitOption;
  logic        hitConfig;
  logic        hitSetup;
  logic        mapped;
  logic        accEdge;
  logic        setupPhase;
  logic        wrEdge;
  logic [7:0]  wrByte;
  logic [7:0]  readByte;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Only the release is delayed; a dip on the pin still resets at once,
  // and every flop below sees one clean release edge
  bwd_reset_sync bwd_reset_sync_inst (
    .clock      (clock),
    .resetn     (resetn),
    .syncResetn (rstN)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Registers sit one word apart, with one unused word before setup; byte address is the index times four
  // A misaligned or unmapped address answers with an error and changes nothing
  assign regIdx     = paddr[17:2];
  assign aligned    = (paddr[1:0] == 2'b00);
  assign hitStatus  = aligned && (regIdx == bwd_pkg::BOARD_STATUS_IDX);
  assign hitControl = aligned && (regIdx == bwd_pkg::BOARD_CONTROL_IDX);
  assign hitOption  = aligned && (regIdx == bwd_pkg::OPTION_ID_IDX);
  assign hitConfig  = aligned && (regIdx == bwd_pkg::WDG_CONFIG_IDX);
  assign hitSetup   = aligned && (regIdx == bwd_pkg::BOARD_SETUP_IDX);
  assign mapped     = hitStatus || hitControl || hitOption || hitConfig || hitSetup;

  // Phases of an APB transfer; the access phase lasts one cycle when ce is high in the setup cycle
  assign setupPhase = psel && !penable;
  assign accEdge    = psel && penable && pready;
  assign wrEdge     = accEdge && pwrite && mapped;
  assign wrByte     = pwdata[7:0];

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Upper bits of every register read as zero
  // Unmapped addresses read zero as well, together with the error
  always_comb begin
    readByte = 8'h00;
    if (hitStatus) begin
      readByte[bwd_pkg::STATUS_FLAG_BIT] = ctl.resetFlag;
    end else if (hitControl) begin
      readByte = control_r;
    end else if (hitOption) begin
      readByte = bwd_pkg::OPTION_ID_VALUE;
    end else if (hitConfig) begin
      readByte = config_r;
    end else if (hitSetup) begin
      readByte[bwd_pkg::READY_LED_BIT] = ready_r;
      readByte[bwd_pkg::RUN_BIT]       = ctl.running;
      readByte[bwd_pkg::USB_ALL_BIT]   = usbAll_r;
      readByte[bwd_pkg::USB_LOW_BIT]   = usbLow_r;
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // Ready follows every setup cycle with ce high after one clock; no wait states, so
  // the answer costs a flop, but with ce low in the setup cycle ready never comes
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (setupPhase) begin
        pready  <= 1'b1;
        pslverr <= !mapped;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // Read data is captured in the setup cycle so the bus sees a flop;
  // it then holds, which spares a clearing path
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      prdata <= 32'h0;
    end else if (ce && setupPhase) begin
      prdata <= (mapped && !pwrite) ? {24'h0, readByte} : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Control register and kick
  // ----------------------------------------------------------------
  // Only a real change of bit 6 counts; writing the same value is no kick
  // A write that meets a complete reset is lost; the reset wins
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      control_r <= bwd_pkg::CONTROL_RESET;
      kick_r    <= 1'b0;
    end else if (ce) begin
      kick_r <= 1'b0;
      if (fullRst_r) begin
        control_r <= bwd_pkg::CONTROL_RESET;
      end else if (wrEdge && hitControl) begin
        control_r <= wrByte;
        kick_r    <= wrByte[bwd_pkg::KICK_BIT] != control_r[bwd_pkg::KICK_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  // Every write clears the flag, even one that leaves the value as it was
  // A new timeout select applies from the next reload of the countdown
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      config_r <= bwd_pkg::CONFIG_RESET;
      cfgWr_r  <= 1'b0;
    end else if (ce) begin
      cfgWr_r <= wrEdge && hitConfig;
      if (fullRst_r) begin
        config_r <= bwd_pkg::CONFIG_RESET;
      end else if (wrEdge && hitConfig) begin
        config_r <= wrByte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Setup register
  // ----------------------------------------------------------------
  // LED and USB enables. The low USB bit takes the common enable on every write, as
  // it cannot be written alone; it is kept as its own flop so that a later
  // part can split the port pairs without touching the read path.
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      ready_r  <= bwd_pkg::SETUP_RESET[bwd_pkg::READY_LED_BIT];
      usbAll_r <= bwd_pkg::SETUP_RESET[bwd_pkg::USB_ALL_BIT];
      usbLow_r <= bwd_pkg::SETUP_RESET[bwd_pkg::USB_LOW_BIT];
    end else if (ce) begin
      if (fullRst_r) begin
        ready_r  <= bwd_pkg::SETUP_RESET[bwd_pkg::READY_LED_BIT];
        usbAll_r <= bwd_pkg::SETUP_RESET[bwd_pkg::USB_ALL_BIT];
        usbLow_r <= bwd_pkg::SETUP_RESET[bwd_pkg::USB_LOW_BIT];
      end else if (wrEdge && hitSetup) begin
        ready_r  <= wrByte[bwd_pkg::READY_LED_BIT];
        usbAll_r <= wrByte[bwd_pkg::USB_ALL_BIT];
        usbLow_r <= wrByte[bwd_pkg::USB_ALL_BIT];
      end
    end
  end

  // The run bit itself lives in the core; here only one-cycle write
  // intents. Both fall back to zero every cycle, so a stale intent from
  // an earlier write can never start or stop the watchdog again.
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      runSet_r   <= 1'b0;
      runClear_r <= 1'b0;
    end else if (ce) begin
      runSet_r   <= 1'b0;
      runClear_r <= 1'b0;
      if (wrEdge && hitSetup && !fullRst_r) begin
        runSet_r   <= wrByte[bwd_pkg::RUN_BIT];
        runClear_r <= !wrByte[bwd_pkg::RUN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Complete reset request
  // ----------------------------------------------------------------
  // Any other value written to the option register is dropped
  // The pulse length itself is timed in the core
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      fullRst_r <= 1'b0;
    end else if (ce) begin
      fullRst_r <= wrEdge && hitOption && (wrByte == bwd_pkg::FULL_RESET_CODE);
    end
  end

  // ----------------------------------------------------------------
  // Core connection
  // ----------------------------------------------------------------
  assign ctl.cfgWr    = cfgWr_r;
  assign ctl.runSet   = runSet_r;
  assign ctl.runClear = runClear_r;
  assign ctl.kick     = kick_r;
  assign ctl.fullRst  = fullRst_r;
  // Lock and timeout select are read live; a lock change takes hold at once, a new select at the next reload
  assign ctl.lock     = config_r[bwd_pkg::CFG_LOCK_BIT];
  assign ctl.tmoSel   = config_r[bwd_pkg::CFG_TMO_LSB +: bwd_pkg::TMO_SEL_W];

  // ----------------------------------------------------------------
  // Watchdog core
  // ----------------------------------------------------------------
  // Counting, reset pulse and flag live in one place so their priorities
  // can be read side by side
  bwd_core bwd_core_inst (
    .clock         (clock),
    .rstN          (rstN),
    .ce            (ce),
    .unitCycles    (32'(UNIT_CYCLES)),
    .ctl           (ctl.core),
    .boardResetN_r (resetOut)
  );

  // ----------------------------------------------------------------
  // Board outputs
  // ----------------------------------------------------------------
  // The core already drives its reset from a flop; the others are copies
  assign boardResetN = resetOut;

  // Activity lags the core by a cycle; software should read the run bit
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      watchdogActive <= 1'b0;
    end else if (ce) begin
      watchdogActive <= ctl.running;
    end
  end

  // LED copy, registered so the pin never glitches on a decode
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      greenLed <= 1'b0;
    end else if (ce) begin
      greenLed <= ready_r;
    end
  end

  // USB power copy; both port pairs share this one enable
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      usbPowerEn <= 1'b0;
    end else if (ce) begin
      usbPowerEn <= usbAll_r;
    end
  end

endmodule : bwd_watchdog

//--- bwd_watchdog_checker.sv
`timescale 1ns/10ps
module bwd_watchdog_checker #(
  parameter int unsigned UNIT_CYCLES = 20
) (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        boardResetN,
  input wire logic        watchdogActive
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [7:0] lowCnt_r;
  logic [3:0] wrAge_r;
  logic [3:0] runAge_r;
  logic       wrSeen_r;
  logic       wrDone;
  assign wrDone = psel && penable && pready && pwrite;

  // Ages saturate so a long idle stretch never wraps into a false cause
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lowCnt_r <= 8'h00;
      wrAge_r  <= 4'hF;
      runAge_r <= 4'hF;
      wrSeen_r <= 1'b0;
    end else begin
      lowCnt_r <= boardResetN ? 8'h00 : (lowCnt_r == 8'hFF ? lowCnt_r : lowCnt_r + 8'h01);
      wrAge_r  <= wrDone ? 4'h0 : (wrAge_r == 4'hF ? wrAge_r : wrAge_r + 4'h1);
      runAge_r <= (wrDone && paddr == {bwd_pkg::BOARD_SETUP_IDX, 2'b00}
                   && pwdata[bwd_pkg::RUN_BIT])
                  ? 4'h0 : (runAge_r == 4'hF ? runAge_r : runAge_r + 4'h1);
      wrSeen_r <= wrSeen_r | wrDone;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_ready_after_setup: assert property (
    psel && !penable && ce |=> pready) else $error("pready missing after setup");
  a_ready_single_cycle: assert property (
    pready |=> !pready) else $error("pready longer than one cycle");
  a_err_misaligned: assert property (
    psel && !penable && ce && paddr[1:0] != 2'b00 |=> pslverr && prdata == 32'h0)
    else $error("misaligned access not refused");
  a_upper_data_zero: assert property (
    pready |-> prdata[31:8] == 24'h0) else $error("upper read data not zero");
  a_pulse_length: assert property (
    $rose(boardResetN) |-> lowCnt_r == 8'(bwd_pkg::RST_HOLD_CYCLES))
    else $error("board reset pulse length");
  a_reset_has_cause: assert property (
    $fell(boardResetN) |-> wrAge_r <= 4'h4 || $past(watchdogActive) || $past(watchdogActive, 2))
    else $error("board reset without cause");
  a_quiet_until_write: assert property (
    !wrSeen_r |-> !watchdogActive && boardResetN) else $error("watchdog active at power-on");
  a_start_needs_run: assert property (
    $rose(watchdogActive) |-> runAge_r <= 4'h5) else $error("watchdog started without run bit");
endmodule : bwd_watchdog_checker

bind bwd_watchdog bwd_watchdog_checker #(.UNIT_CYCLES(UNIT_CYCLES)) bwd_watchdog_checker_inst (
  .clock, .resetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .boardResetN, .watchdogActive);

//--- bwd_watchdog_tb.sv
`timescale 1ns/10ps
module bwd_watchdog_tb;
  localparam int unsigned U = 20;
  localparam logic [15:0] STA = bwd_pkg::BOARD_STATUS_IDX;
  localparam logic [15:0] CTL = bwd_pkg::BOARD_CONTROL_IDX;
  localparam logic [15:0] OPT = bwd_pkg::OPTION_ID_IDX;
  localparam logic [15:0] CFG = bwd_pkg::WDG_CONFIG_IDX;
  localparam logic [15:0] SET = bwd_pkg::BOARD_SETUP_IDX;
  logic        clock = 1'b0, resetn = 1'b0, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdV;
  logic        pready, pslverr, boardResetN, watchdogActive, greenLed, usbPowerEn, errV;
  int          n_errors = 0, comparisons = 0, n;

  // Free-running 125 MHz clock
  always #4 clock = ~clock;

  bwd_watchdog #(.UNIT_CYCLES(U)) bwd_watchdog_inst (
    .clock, .resetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .boardResetN, .watchdogActive, .greenLed, .usbPowerEn);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task conclude;
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [17:0] a, input logic [7:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rdV = prdata;
    errV = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin
      chk("pready wait", 0, 1);
      conclude();
    end
  endtask : apb

  task wr(input logic [15:0] x, input logic [7:0] d);
    apb(1'b1, {x, 2'b00}, d);
  endtask : wr

  // Two idle cycles first: core state lands two edges after a write
  task rd(input logic [15:0] x);
    repeat (2) @(posedge clock);
    apb(1'b0, {x, 2'b00}, 8'h00);
  endtask : rd

  task waitLvl(input logic lvl, input int lim);
    n = 0;
    while (boardResetN !== lvl && n < lim) begin
      @(posedge clock);
      n++;
    end
    if (boardResetN !== lvl) begin
      chk("board reset wait", 0, 1);
      conclude();
    end
  endtask : waitLvl

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    logic [15:0] ix [4];
    logic [7:0]  ev [4];
    ix = '{CTL, CFG, SET, OPT};
    ev = '{bwd_pkg::CONTROL_RESET, bwd_pkg::CONFIG_RESET,
           bwd_pkg::SETUP_RESET, bwd_pkg::OPTION_ID_VALUE};
    rd(STA); chk("flag", rdV[4], 0);
    for (int k = 0; k < 4; k++) begin
      rd(ix[k]); chk("reset value", rdV, {24'h0, ev[k]});
      chk("good access err", errV, 0);
    end
    apb(1'b0, 18'h20810, 8'h00); chk("unmapped err", errV, 1);
    apb(1'b1, 18'h2080D, 8'hFF); chk("misaligned err", errV, 1);
    wr(STA, 8'h10); rd(STA); chk("status read only", rdV[4], 0);
    chk("idle outputs", {watchdogActive, boardResetN}, 2'b01);
  endtask : t_reset

  task t_expiry;
    wr(CFG, 8'h01);
    wr(SET, 8'h40);
    rd(SET); chk("run bit", rdV, 32'h40);
    for (int k = 0; k < 4; k++) begin
      repeat (30) @(posedge clock);
      wr(CTL, k[0] ? 8'h00 : 8'h40);
      chk("kept alive", boardResetN, 1);
    end
    waitLvl(1'b0, 3 * U); chk("timeout sel1", n >= 2 * U - 2 && n <= 2 * U + 6, 1);
    waitLvl(1'b1, 200);
    rd(STA); chk("flag set", rdV[4], 1);
    rd(SET); chk("run cleared", rdV, 0);
  endtask : t_expiry

  task t_reenable;
    wr(SET, 8'h40); waitLvl(1'b0, 6);
    waitLvl(1'b1, 200);
    rd(STA); chk("flag kept", rdV[4], 1);
    wr(CFG, 8'h00); rd(STA); chk("flag cleared", rdV[4], 0);
  endtask : t_reenable

  task t_lock;
    wr(CFG, 8'h87); wr(SET, 8'h40); wr(SET, 8'h00);
    rd(SET); chk("locked run", rdV, 32'h40);
    chk("still active", watchdogActive, 1);
    wr(CFG, 8'h07); wr(SET, 8'h00);
    rd(SET); chk("stopped", rdV, 0);
    repeat (10 * U) @(posedge clock);
    chk("no expiry", {watchdogActive, boardResetN}, 2'b01);
  endtask : t_lock

  // Clock enable low must hold the countdown exactly where it stands
  task t_freeze;
    wr(CFG, 8'h00); wr(SET, 8'h40);
    repeat (5) @(posedge clock);
    ce <= 1'b0;
    repeat (3 * U) @(posedge clock);
    chk("frozen count", {watchdogActive, boardResetN}, 2'b11);
    ce <= 1'b1;
    waitLvl(1'b0, 2 * U); chk("rest of timeout", n >= U / 2 && n <= U, 1);
    waitLvl(1'b1, 200);
  endtask : t_freeze

  task t_full;
    wr(CFG, 8'h00); wr(SET, 8'hC2);
    waitLvl(1'b0, 2 * U); chk("timeout sel0", n >= U - 2 && n <= U + 6, 1);
    chk("led and usb", {greenLed, usbPowerEn}, 2'b11);
    waitLvl(1'b1, 200);
    wr(OPT, 8'h5A); rd(STA); chk("flag survives", rdV[4], 1);
    wr(OPT, bwd_pkg::FULL_RESET_CODE); waitLvl(1'b0, 6);
    waitLvl(1'b1, 200);
    rd(STA); chk("flag after full", rdV[4], 0);
    rd(SET); chk("setup after full", rdV, 32'h01);
    chk("outputs after full", {greenLed, usbPowerEn, watchdogActive}, 3'b000);
  endtask : t_full

  // Main sequence
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    t_reset();
    t_expiry();
    t_reenable();
    t_lock();
    t_freeze();
    t_full();
    conclude();
  end
endmodule : bwd_watchdog_tb
